//--- core/sos_top.sv
// status pin a selector with axi4-lite register file
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// RL1 - two-bit primary detector threshold, code 3 reserved
// RL2 - source bits 7:4 pick los, lol
// RL3 - codes 3,4,11 route divider halves
// RL4 - codes 8,13,14 calibration, eeprom, switch
// RL5 - code 10 drives interrupt summary
// RL6 - bit 3 sets pin polarity
// RL7 - test configuration overrides select and polarity
// RL8 - reserved codes inactive, bits 2:0 zero
module sos_top
  import sos_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_input_signal_missing,
  input wire logic secondary_input_signal_missing,
  input wire logic lock_lost_flag,
  input wire logic r_div_out,
  input wire logic r_div_bypassed,
  input wire logic n_div_out,
  input wire logic m_div_out,
  input wire logic m_div_bypassed,
  input wire logic vco_cal_active,
  input wire logic eeprom_active,
  input wire logic auto_select_active,
  input wire logic primary_ref_selected,
  output logic [1:0] primary_threshold_choice,
  output logic status_pin_a,
  output logic irq_summary
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {primary_ref_selected, auto_select_active, eeprom_active, vco_cal_active, m_div_bypassed,
    m_div_out, n_div_out, r_div_bypassed, r_div_out, lock_lost_flag, secondary_input_signal_missing,
    primary_input_signal_missing};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic s_pri_los, s_sec_los, s_lol, s_r, s_r_byp, s_n, s_m, s_m_byp, s_cal, s_eep, s_auto, s_pri_sel;
  assign {s_pri_sel, s_auto, s_eep, s_cal, s_m_byp, s_m, s_n, s_r_byp, s_r, s_lol, s_sec_los, s_pri_los} = sync2_reg;
  // ----------------------------------------
  // divide-by-two taps
  // ----------------------------------------
  logic r_prev_reg, n_prev_reg, m_prev_reg;
  logic r_half_reg, n_half_reg, m_half_reg;
  logic pri_sel_prev_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_prev_reg <= 1'b0;
      n_prev_reg <= 1'b0;
      m_prev_reg <= 1'b0;
      r_half_reg <= 1'b0;
      n_half_reg <= 1'b0;
      m_half_reg <= 1'b0;
      pri_sel_prev_reg <= 1'b0;
    end else begin
      r_prev_reg <= s_r;
      n_prev_reg <= s_n;
      m_prev_reg <= s_m;
      pri_sel_prev_reg <= s_pri_sel;
      if (s_r && !r_prev_reg && !s_r_byp) begin
        r_half_reg <= ~r_half_reg; // RL3
      end
      if (s_n && !n_prev_reg) begin
        n_half_reg <= ~n_half_reg; // RL3
      end
      if (s_m && !m_prev_reg && !s_m_byp) begin
        m_half_reg <= ~m_half_reg; // RL3
      end
    end
  end
  logic switch_event;
  assign switch_event = s_auto && s_pri_sel && !pri_sel_prev_reg; // RL4
  // ----------------------------------------
  // interrupt status, clear, enable
  // ----------------------------------------
  logic [SOS_IRQ_BITS-1:0] irq_status_reg, irq_status_next, irq_enable_reg, irq_events, irq_clear;
  logic lol_prev_reg, pri_los_prev_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lol_prev_reg <= 1'b0;
      pri_los_prev_reg <= 1'b0;
    end else begin
      lol_prev_reg <= s_lol;
      pri_los_prev_reg <= s_pri_los;
    end
  end
  assign irq_events = {switch_event, s_sec_los, s_pri_los && !pri_los_prev_reg, s_lol && !lol_prev_reg};
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic aw_held_reg, w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [3:0] source_reg;
  logic polarity_reg;
  logic [1:0] thresh_reg;
  logic test_active_reg, test_level_reg;
  logic do_write, wr_lane0;
  logic [11:0] wr_addr;
  logic wr_hit;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = 12'(awaddr_reg) & 12'hFFC;
  assign wr_lane0 = do_write && wstrb_reg[0];
  assign wr_hit = wr_addr == SOS_ADDR_PIN_A || wr_addr == SOS_ADDR_THRESH || wr_addr == SOS_ADDR_IRQ_CLEAR ||
    wr_addr == SOS_ADDR_IRQ_ENABLE || wr_addr == SOS_ADDR_TEST;
  assign irq_clear = (wr_lane0 && wr_addr == SOS_ADDR_IRQ_CLEAR) ? wdata_reg[SOS_IRQ_BITS-1:0] : '0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SOS_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? SOS_RESP_OKAY : SOS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      source_reg <= SOS_SRC_RESET;
      polarity_reg <= SOS_POL_RESET;
      thresh_reg <= SOS_THRESH_RESET;
      irq_enable_reg <= '0;
      test_active_reg <= 1'b0;
      test_level_reg <= 1'b0;
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_lane0 && wr_addr == SOS_ADDR_PIN_A) begin
        source_reg <= wdata_reg[SOS_SRC_MSB:SOS_SRC_LSB]; // RL2
        polarity_reg <= wdata_reg[SOS_POL_BIT]; // RL6
      end
      if (wr_lane0 && wr_addr == SOS_ADDR_THRESH && wdata_reg[1:0] != SOS_THRESH_RESERVED) begin
        thresh_reg <= wdata_reg[1:0]; // RL1
      end
      if (wr_lane0 && wr_addr == SOS_ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= wdata_reg[SOS_IRQ_BITS-1:0];
      end
      if (wr_lane0 && wr_addr == SOS_ADDR_TEST) begin
        test_active_reg <= wdata_reg[0]; // RL7
        test_level_reg <= wdata_reg[1];
      end
    end
  end
  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  logic [11:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_hit;
  assign rd_addr = 12'(s_axi_araddr) & 12'hFFC;
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (rd_addr)
      SOS_ADDR_PIN_A: rd_word = {24'h000000, source_reg, polarity_reg, 3'h0}; // RL8
      SOS_ADDR_THRESH: rd_word = {30'h0, thresh_reg};
      SOS_ADDR_IRQ_STATUS: rd_word = {28'h0000000, irq_status_reg};
      SOS_ADDR_IRQ_CLEAR: rd_word = '0;
      SOS_ADDR_IRQ_ENABLE: rd_word = {28'h0000000, irq_enable_reg};
      SOS_ADDR_TEST: rd_word = {30'h0, test_level_reg, test_active_reg};
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SOS_RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? SOS_RESP_OKAY : SOS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ----------------------------------------
  // outputs and pin selector
  // ----------------------------------------
  logic irq_level;
  assign irq_level = |(irq_status_reg & irq_enable_reg); // RL5
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_summary <= 1'b0;
      primary_threshold_choice <= SOS_THRESH_RESET;
    end else begin
      irq_summary <= irq_level;
      primary_threshold_choice <= thresh_reg; // RL1
    end
  end
  logic [3:0] sel_source;
  logic sel_raw;
  logic eep_sel, sw_sel;
  sos_sel_if sel_bus ();
  // eeprom and switch codes reuse the pri los code and condition bit 0 via remap
  assign eep_sel = source_reg == SOS_SRC_EEPROM; // RL4
  assign sw_sel = source_reg == SOS_SRC_SWITCH; // RL4
  assign sel_source = (eep_sel || sw_sel) ? SOS_SRC_PRI_LOS : source_reg;
  assign sel_raw = eep_sel ? s_eep : (sw_sel ? switch_event : s_pri_los);
  assign sel_bus.source = sel_source;
  assign sel_bus.polarity = polarity_reg;
  assign sel_bus.test_active = test_active_reg;
  assign sel_bus.test_level = test_level_reg;
  assign sel_bus.conditions = {m_half_reg, irq_level, s_cal, n_half_reg, r_half_reg, s_lol, s_sec_los, sel_raw};
  sos_pin_select u_select (
    .clk(clk),
    .reset(reset),
    .bus(sel_bus),
    .pin_level(status_pin_a)
  );
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_irq_sticky: assert property (@(posedge clk) disable iff (reset)
    (irq_events[0]) |=> irq_status_reg[0])
    else $error("interrupt event lost");
  a_irq_level: assert property (@(posedge clk) disable iff (reset) // RL5
    (|(irq_status_reg & irq_enable_reg)) |=> irq_summary)
    else $error("summary not raised");
  a_thresh_rsvd: assert property (@(posedge clk) disable iff (reset) // RL1
    thresh_reg != SOS_THRESH_RESERVED)
    else $error("reserved threshold stored");
  a_rsvd_inactive: assert property (@(posedge clk) disable iff (reset) // RL8
    (!test_active_reg && source_reg == 4'h5) |=> status_pin_a == !$past(polarity_reg))
    else $error("reserved code not inactive");
  a_r_bypass_hold: assert property (@(posedge clk) disable iff (reset) // RL3
    s_r_byp |=> $stable(r_half_reg))
    else $error("bypassed r tap toggled");
  a_m_bypass_hold: assert property (@(posedge clk) disable iff (reset) // RL3
    s_m_byp |=> $stable(m_half_reg))
    else $error("bypassed m tap toggled");
  a_cal_route: assert property (@(posedge clk) disable iff (reset) // RL4
    (!test_active_reg && polarity_reg && source_reg == SOS_SRC_CAL) |=> status_pin_a == $past(s_cal))
    else $error("calibration not on pin");
  a_eeprom_route: assert property (@(posedge clk) disable iff (reset) // RL4
    (!test_active_reg && polarity_reg && source_reg == SOS_SRC_EEPROM) |=> status_pin_a == $past(s_eep))
    else $error("eeprom activity not on pin");
  a_switch_route: assert property (@(posedge clk) disable iff (reset) // RL4
    (!test_active_reg && polarity_reg && source_reg == SOS_SRC_SWITCH) |=> status_pin_a == $past(switch_event))
    else $error("switch event not on pin");
  a_los_route: assert property (@(posedge clk) disable iff (reset) // RL2
    (!test_active_reg && polarity_reg && source_reg == SOS_SRC_SEC_LOS) |=> status_pin_a == $past(s_sec_los))
    else $error("secondary los not on pin");
endmodule

//--- shared/sos_pkg.sv
// constants for the status output selector
package sos_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int SOS_REG_INDEX_PIN_A = 'h1B;
  localparam int SOS_REG_INDEX_THRESH = 'h1A;
  localparam int SOS_REG_INDEX_IRQ_STATUS = 'h40;
  localparam int SOS_REG_INDEX_IRQ_CLEAR = 'h41;
  localparam int SOS_REG_INDEX_IRQ_ENABLE = 'h42;
  localparam int SOS_REG_INDEX_TEST = 'h43;
  localparam logic [11:0] SOS_ADDR_PIN_A = 12'(SOS_REG_INDEX_PIN_A * 4);
  localparam logic [11:0] SOS_ADDR_THRESH = 12'(SOS_REG_INDEX_THRESH * 4);
  localparam logic [11:0] SOS_ADDR_IRQ_STATUS = 12'(SOS_REG_INDEX_IRQ_STATUS * 4);
  localparam logic [11:0] SOS_ADDR_IRQ_CLEAR = 12'(SOS_REG_INDEX_IRQ_CLEAR * 4);
  localparam logic [11:0] SOS_ADDR_IRQ_ENABLE = 12'(SOS_REG_INDEX_IRQ_ENABLE * 4);
  localparam logic [11:0] SOS_ADDR_TEST = 12'(SOS_REG_INDEX_TEST * 4);
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int SOS_SRC_MSB = 7;
  localparam int SOS_SRC_LSB = 4;
  localparam int SOS_POL_BIT = 3;
  localparam logic [3:0] SOS_SRC_RESET = 4'h5;
  localparam logic SOS_POL_RESET = 1'b1;
  localparam logic [1:0] SOS_THRESH_RESET = 2'h1;
  localparam logic [1:0] SOS_THRESH_RESERVED = 2'h3;
  localparam logic [1:0] SOS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SOS_RESP_SLVERR = 2'h2;
  localparam int SOS_IRQ_BITS = 4;
  // ----------------------------------------
  // source codes
  // ----------------------------------------
  localparam logic [3:0] SOS_SRC_PRI_LOS = 4'h0;
  localparam logic [3:0] SOS_SRC_SEC_LOS = 4'h1;
  localparam logic [3:0] SOS_SRC_LOL = 4'h2;
  localparam logic [3:0] SOS_SRC_R_DIV2 = 4'h3;
  localparam logic [3:0] SOS_SRC_N_DIV2 = 4'h4;
  localparam logic [3:0] SOS_SRC_CAL = 4'h8;
  localparam logic [3:0] SOS_SRC_IRQ = 4'hA;
  localparam logic [3:0] SOS_SRC_M_DIV2 = 4'hB;
  localparam logic [3:0] SOS_SRC_EEPROM = 4'hD;
  localparam logic [3:0] SOS_SRC_SWITCH = 4'hE;
  // ----------------------------------------
  // threshold codes in millivolts
  // ----------------------------------------
  localparam int SOS_THRESH_MV_0 = 200;
  localparam int SOS_THRESH_MV_1 = 300;
  localparam int SOS_THRESH_MV_2 = 400;
endpackage

//--- shared/sos_sel_if.sv
// carrier between register file and pin selector
`timescale 1ns/1ps
interface sos_sel_if;
  logic [3:0] source;
  logic polarity;
  logic test_active;
  logic test_level;
  logic [7:0] conditions;
  modport ctrl (output source, output polarity, output test_active, output test_level, output conditions);
  modport sel (input source, input polarity, input test_active, input test_level, input conditions);
endinterface

//--- core/sos_pin_select.sv
// status pin source mux with polarity and test override
`timescale 1ns/1ps
module sos_pin_select
  import sos_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  sos_sel_if.sel bus,
  output logic pin_level
);
  // ----------------------------------------
  // selection
  // ----------------------------------------
  // condition bits: 0 pri los or remapped source, 1 sec los, 2 lol, 3 r/2, 4 n/2, 5 cal, 6 irq, 7 m/2
  logic active_raw;
  logic driven;
  always_comb begin
    case (bus.source)
      SOS_SRC_PRI_LOS: active_raw = bus.conditions[0]; // RL2
      SOS_SRC_SEC_LOS: active_raw = bus.conditions[1]; // RL2
      SOS_SRC_LOL: active_raw = bus.conditions[2]; // RL2
      SOS_SRC_R_DIV2: active_raw = bus.conditions[3]; // RL3
      SOS_SRC_N_DIV2: active_raw = bus.conditions[4]; // RL3
      SOS_SRC_CAL: active_raw = bus.conditions[5]; // RL4
      SOS_SRC_IRQ: active_raw = bus.conditions[6]; // RL5
      SOS_SRC_M_DIV2: active_raw = bus.conditions[7]; // RL3
      default: active_raw = 1'b0; // RL8
    endcase
  end
  assign driven = bus.test_active ? bus.test_level : (bus.polarity ? active_raw : ~active_raw); // RL6 RL7
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= driven;
    end
  end
  a_pol_high: assert property (@(posedge clk) disable iff (reset) // RL6
    (!bus.test_active && bus.polarity && bus.source == SOS_SRC_LOL) |=> pin_level == $past(bus.conditions[2]))
    else $error("active high lol not on pin");
  a_test_wins: assert property (@(posedge clk) disable iff (reset) // RL7
    bus.test_active |=> pin_level == $past(bus.test_level))
    else $error("test override not on pin");
endmodule

//--- tb/sos_top_bench.sv
// self-checking bench for the status output selector
`timescale 1ns/1ps
module sos_top_bench
  import sos_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int CYCLE_LIMIT = 6000;
  logic clk;
  logic reset;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [4:0] cond;
  logic [2:0] divs;
  logic [1:0] bypass;
  logic auto_select_active;
  logic primary_ref_selected;
  logic [1:0] primary_threshold_choice;
  logic status_pin_a;
  logic irq_summary;
  int checks = 0;
  int fail_count = 0;
  int cycle_count = 0;

  sos_top sos_top_inst (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .primary_input_signal_missing(cond[0]), .secondary_input_signal_missing(cond[1]),
    .lock_lost_flag(cond[2]), .vco_cal_active(cond[3]), .eeprom_active(cond[4]),
    .r_div_out(divs[0]), .n_div_out(divs[1]), .m_div_out(divs[2]),
    .r_div_bypassed(bypass[0]), .m_div_bypassed(bypass[1]),
    .auto_select_active(auto_select_active), .primary_ref_selected(primary_ref_selected),
    .primary_threshold_choice(primary_threshold_choice), .status_pin_a(status_pin_a),
    .irq_summary(irq_summary)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == CYCLE_LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // level expected on the pin for the static sources
  function automatic logic exp_pin(input logic [3:0] s, input logic p, input logic [4:0] c);
    logic a;
    case (s)
      SOS_SRC_PRI_LOS: a = c[0];
      SOS_SRC_SEC_LOS: a = c[1];
      SOS_SRC_LOL: a = c[2];
      SOS_SRC_CAL: a = c[3];
      SOS_SRC_EEPROM: a = c[4];
      default: a = 1'b0;
    endcase
    return p ? a : !a;
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] s;
    logic p;
    logic [1:0] th;
    logic [31:0] v;
    logic [31:0] n;
    void'($urandom(88691));
    reset = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, cond, divs, bypass} = '0;
    {auto_select_active, primary_ref_selected} = '0;
    s_axi_wstrb = 4'hF;
    wait_clk(3);
    chk("pin during reset", 1'b0, status_pin_a);
    chk("threshold during reset", SOS_THRESH_RESET, primary_threshold_choice);
    wait_clk(3);
    reset <= 1'b0;
    axi_read(SOS_ADDR_PIN_A, d, r);
    chk("pin_a config reset", 32'h58, d);
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      axi_write(SOS_ADDR_PIN_A, v, r);
      axi_read(SOS_ADDR_PIN_A, d, r);
      chk("pin_a readback", {24'h0, v[7:3], 3'h0}, d);
    end
    // every static source under both polarities
    for (int k = 0; k < 32; k++) begin
      s = 4'(k);
      p = k[4];
      if (s inside {SOS_SRC_R_DIV2, SOS_SRC_N_DIV2, SOS_SRC_M_DIV2, SOS_SRC_SWITCH}) continue;
      cond <= 5'($urandom);
      axi_write(SOS_ADDR_PIN_A, {24'h0, s, p, 3'h0}, r);
      chk("bresp", SOS_RESP_OKAY, r);
      wait_clk(6);
      chk("status_pin_a", exp_pin(s, p, cond), status_pin_a);
    end
    // divider taps toggle on rising edges only
    for (int k = 0; k < 3; k++) begin
      s = (k == 0) ? SOS_SRC_R_DIV2 : (k == 1) ? SOS_SRC_N_DIV2 : SOS_SRC_M_DIV2;
      divs <= 3'h0;
      bypass <= 2'h0;
      axi_write(SOS_ADDR_PIN_A, {24'h0, s, 1'b1, 3'h0}, r);
      wait_clk(6);
      p = status_pin_a;
      divs <= 3'h7;
      wait_clk(6);
      chk("divider rise", !p, status_pin_a);
      divs <= 3'h0;
      wait_clk(6);
      chk("divider fall", !p, status_pin_a);
      bypass <= 2'h3;
      divs <= 3'h7;
      wait_clk(6);
      chk("bypassed tap", (k == 1) ? p : !p, status_pin_a);
    end
    // threshold codes, reserved code ignored
    th = SOS_THRESH_RESET;
    for (int k = 0; k < 4; k++) begin
      if (2'(k) != SOS_THRESH_RESERVED) th = 2'(k);
      axi_write(SOS_ADDR_THRESH, 32'(k), r);
      wait_clk(2);
      chk("threshold out", th, primary_threshold_choice);
    end
    axi_read(SOS_ADDR_THRESH, d, r);
    chk("threshold readback", {30'h0, th}, d);
    // test override beats select and polarity
    cond <= 5'h0;
    axi_write(SOS_ADDR_PIN_A, 32'h00, r);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 32'h3 : (k == 1) ? 32'h1 : 32'h0;
      axi_write(SOS_ADDR_TEST, v, r);
      wait_clk(4);
      chk("test override", v[0] ? v[1] : 1'b1, status_pin_a);
    end
    // unmapped place
    axi_write(12'h7F0, 32'hFF, r);
    chk("unmapped bresp", SOS_RESP_SLVERR, r);
    axi_read(12'h7F0, d, r);
    chk("unmapped rresp", SOS_RESP_SLVERR, r);
    // interrupt summary on the pin: raise, mask, clear
    auto_select_active <= 1'b1;
    wait_clk(6);
    axi_write(SOS_ADDR_IRQ_CLEAR, 32'hF, r);
    axi_write(SOS_ADDR_IRQ_ENABLE, 32'h1, r);
    axi_write(SOS_ADDR_PIN_A, 32'hA8, r);
    axi_read(SOS_ADDR_IRQ_STATUS, d, r);
    chk("irq status cleared", 32'h0, d & 32'hF);
    cond <= 5'h04;
    primary_ref_selected <= 1'b1;
    wait_clk(8);
    chk("irq_summary raised", 1'b1, irq_summary);
    chk("pin shows irq", 1'b1, status_pin_a);
    axi_read(SOS_ADDR_IRQ_STATUS, d, r);
    chk("irq status events", 32'h9, d & 32'hF);
    axi_write(SOS_ADDR_IRQ_ENABLE, 32'h0, r);
    wait_clk(4);
    chk("irq masked", 1'b0, irq_summary);
    chk("pin irq masked", 1'b0, status_pin_a);
    axi_write(SOS_ADDR_IRQ_ENABLE, 32'h1, r);
    axi_write(SOS_ADDR_IRQ_CLEAR, 32'h1, r);
    wait_clk(4);
    chk("irq cleared", 1'b0, irq_summary);
    axi_read(SOS_ADDR_IRQ_STATUS, d, r);
    chk("irq status after clear", 32'h8, d & 32'hF);
    // switch to primary shows as a single-cycle pulse
    axi_write(SOS_ADDR_PIN_A, {24'h0, SOS_SRC_SWITCH, 1'b1, 3'h0}, r);
    primary_ref_selected <= 1'b0;
    wait_clk(6);
    primary_ref_selected <= 1'b1;
    n = 32'h0;
    repeat (10) begin
      @(posedge clk);
      n = n + 32'(status_pin_a);
    end
    chk("switch pulse", 32'h1, n);
    give_verdict();
  end
endmodule
